// *** design/ifsb_pkg.sv ***
// =====================================================================
// Interrupt flag status bank constants
`default_nettype none
package ifsb_pkg;

	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 16;

	// =================================================================
	// Register offsets (byte addresses)
	localparam logic [7:0] OFS_FLAGS  = 8'h00;
	localparam logic [7:0] OFS_CLEAR  = 8'h04;
	localparam logic [7:0] OFS_ENABLE = 8'h08;

	// =================================================================
	// Field positions of the flag register
	localparam int unsigned BIT_UART_ONE_ERR = 1;
	localparam int unsigned BIT_UART_TWO_ERR = 2;
	localparam int unsigned BIT_DMA_CH6_DONE = 4;
	localparam int unsigned BIT_DMA_CH7_DONE = 5;
	localparam int unsigned BIT_CAN_ONE_TX   = 6;
	localparam int unsigned BIT_CAN_TWO_TX   = 7;

	// =================================================================
	// Implemented bits and reset values
	localparam logic [15:0] IMPL_MASK   = 16'h00F6;
	localparam logic [15:0] FLAGS_RESET = 16'h0000;
	localparam logic [15:0] EN_RESET    = 16'h0000;

endpackage : ifsb_pkg

`default_nettype wire

// *** design/ifsb_flag_cell.sv ***
`timescale 1ns/1ps
`default_nettype none

// =====================================================================
// One sticky flag bit with direct write and write-one-to-clear
module ifsb_flag_cell #(
	parameter bit IMPL = 1'b1
) (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic rst_n,
	// Event and software access
	input  wire logic event_i,
	input  wire logic wr_i,
	input  wire logic wdata_i,
	input  wire logic clr_i,
	// Flag state
	output logic      flag_o
);

	logic flag_q;
	logic flag_d;

	// =================================================================
	// Next value
	always_comb begin
		flag_d = flag_q;
		if (wr_i) begin
			flag_d = wdata_i;
		end
		if (clr_i) begin
			flag_d = 1'b0;
		end
		if (event_i) begin
			flag_d = 1'b1;
		end
		if (!IMPL) begin
			flag_d = 1'b0;
		end
	end

	// =================================================================
	// Register
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= flag_d;
		end
	end

	assign flag_o = flag_q;

endmodule // ifsb_flag_cell

`default_nettype wire

// *** design/ifsb_interrupt_flag_status_bank_four.sv ***
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none


// =====================================================================
// Interrupt flag status register four with enable and interrupt output
module ifsb_interrupt_flag_status_bank_four (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	// Peripheral request pulses
	input  wire logic        can_two_tx_request,
	input  wire logic        can_one_tx_request,
	input  wire logic        dma_ch7_done,
	input  wire logic        dma_ch6_done,
	input  wire logic        uart_two_error,
	input  wire logic        uart_one_error,
	// Interrupt
	output logic             irq
);

	logic [15:0] event_vec;
	logic [15:0] flags;
	logic        wr_flags;
	logic        wr_clear;
	logic        wr_enable;
	logic [15:0] enable_q;
	logic [15:0] enable_d;
	logic [15:0] rdata_q;
	logic [15:0] rdata_d;
	logic        irq_q;
	logic        irq_d;

	// =================================================================
	// Event routing
	always_comb begin
		event_vec = 16'h0000;
		event_vec[ifsb_pkg::BIT_CAN_TWO_TX]   = can_two_tx_request;
		event_vec[ifsb_pkg::BIT_CAN_ONE_TX]   = can_one_tx_request;
		event_vec[ifsb_pkg::BIT_DMA_CH7_DONE] = dma_ch7_done;
		event_vec[ifsb_pkg::BIT_DMA_CH6_DONE] = dma_ch6_done;
		event_vec[ifsb_pkg::BIT_UART_TWO_ERR] = uart_two_error;
		event_vec[ifsb_pkg::BIT_UART_ONE_ERR] = uart_one_error;
	end

	// =================================================================
	// Write decode
	assign wr_flags  = reg_wr && (reg_addr == ifsb_pkg::OFS_FLAGS);
	assign wr_clear  = reg_wr && (reg_addr == ifsb_pkg::OFS_CLEAR);
	assign wr_enable = reg_wr && (reg_addr == ifsb_pkg::OFS_ENABLE);

	// =================================================================
	// Flag bits; event wins over software write or clear
	for (genvar i = 0; i < 16; i++) begin : g_flag
		ifsb_flag_cell #(
			.IMPL (ifsb_pkg::IMPL_MASK[i])
		) u_cell (
			.sys_clk (sys_clk),
			.rst_n   (rst_n),
			.event_i (event_vec[i]),
			.wr_i    (wr_flags),
			.wdata_i (reg_wdata[i]),
			.clr_i   (wr_clear && reg_wdata[i]),
			.flag_o  (flags[i])
		);
	end

	// =================================================================
	// Enable, read data and interrupt next values
	always_comb begin
		enable_d = enable_q;
		if (wr_enable) begin
			enable_d = reg_wdata & ifsb_pkg::IMPL_MASK;
		end
		rdata_d = 16'h0000;
		if (reg_rd) begin
			case (reg_addr)
				ifsb_pkg::OFS_FLAGS:  rdata_d = flags & ifsb_pkg::IMPL_MASK;
				ifsb_pkg::OFS_ENABLE: rdata_d = enable_q;
				default:              rdata_d = 16'h0000;
			endcase
		end
		irq_d = |(flags & enable_q);
	end

	// =================================================================
	// Registers
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			enable_q <= ifsb_pkg::EN_RESET;
			rdata_q  <= 16'h0000;
			irq_q    <= 1'b0;
		end else begin
			enable_q <= enable_d;
			rdata_q  <= rdata_d;
			irq_q    <= irq_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign irq       = irq_q;

endmodule // ifsb_interrupt_flag_status_bank_four

`default_nettype wire

// *** sim/ifsb_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
// ====
// Flag bank checks
module ifsb_sva (
	input wire logic        sys_clk,
	input wire logic        rst_n,
	input wire logic        reg_rd,
	input wire logic        reg_wr,
	input wire logic [7:0]  reg_addr,
	input wire logic [15:0] reg_rdata,
	input wire logic        irq,
	input wire logic        can_two_tx_request,
	input wire logic        dma_ch7_done,
	input wire logic        uart_one_error
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence rd_flags;
		reg_rd && reg_addr == 8'h00;
	endsequence
	a_can_sets_flag:
		assert property (can_two_tx_request ##1 rd_flags |=> reg_rdata[7]) else $error("can flag");
	a_dma_sets_flag:
		assert property (dma_ch7_done ##1 rd_flags |=> reg_rdata[5]) else $error("dma flag");
	a_uart_sets_flag:
		assert property (uart_one_error ##1 rd_flags |=> reg_rdata[1]) else $error("uart flag");
	a_irq_holds:
		assert property (irq && !$past(reg_wr) |=> irq) else $error("irq dropped");
	a_idle_rdata_zero:
		assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("idle data");
	a_unimpl_zero:
		assert property ((reg_rdata & 16'hFF09) == 16'h0000) else $error("unused bits");
	a_reset_clears:
		assert property (disable iff (1'b0) !rst_n |=> !irq && reg_rdata == 16'h0000) else $error("reset");
endmodule // ifsb_sva
bind ifsb_interrupt_flag_status_bank_four ifsb_sva u_sva (.sys_clk, .rst_n, .reg_rd, .reg_wr, .reg_addr,
	.reg_rdata, .irq, .can_two_tx_request, .dma_ch7_done, .uart_one_error);
`default_nettype wire

// *** sim/ifsb_peri_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ====
// Peripherals raising one-cycle request pulses
module ifsb_peri_model (
	input  wire logic       sys_clk,
	input  wire logic [5:0] fire,
	output logic      [5:0] pulse_q
);
	always_ff @(posedge sys_clk) begin
		pulse_q <= fire;
	end
endmodule // ifsb_peri_model
`default_nettype wire

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; $display("wrong value %0t got %0h expected %0h", $time, (a), (b)); end end
// ====
// Flag bank bench
module tb_top;
	logic        sys_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic [15:0] reg_rdata;
	logic [5:0]  fire = 6'h00;
	logic [5:0]  pulse;
	logic        irq;
	int          err_total = 0;
	int          checks = 0;
	always #5 sys_clk = ~sys_clk;
	ifsb_peri_model u_peri (.sys_clk, .fire, .pulse_q(pulse));
	ifsb_interrupt_flag_status_bank_four uut (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .can_two_tx_request(pulse[5]), .can_one_tx_request(pulse[4]), .dma_ch7_done(pulse[3]),
		.dma_ch6_done(pulse[2]), .uart_two_error(pulse[1]), .uart_one_error(pulse[0]), .irq);
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		`CHK(reg_rdata, e)
	endtask
	task automatic hit(input logic [5:0] m);
		@(posedge sys_clk);
		fire <= m;
		@(posedge sys_clk);
		fire <= 6'h00;
	endtask
	task automatic test_done();
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd(8'h00, 16'h0000);
		rd(8'h08, 16'h0000);
		for (int i = 0; i < 6; i++) begin
			hit(6'h01 << i);
			rd(8'h00, 16'h0001 << (i < 2 ? i + 1 : i + 2));
			`CHK(irq, 1'b0)
			wr(8'h00, 16'h0000);
			rd(8'h00, 16'h0000);
		end
		wr(8'h08, 16'hFFFF);
		rd(8'h08, 16'h00F6);
		hit(6'h3F);
		repeat (4) @(posedge sys_clk);
		rd(8'h00, 16'h00F6);
		`CHK(irq, 1'b1)
		wr(8'h04, 16'h00F6);
		rd(8'h00, 16'h0000);
		`CHK(irq, 1'b0)
		wr(8'h00, 16'hFFFF);
		rd(8'h00, 16'h00F6);
		wr(8'h04, 16'h0006);
		rd(8'h00, 16'h00F0);
		rd(8'h04, 16'h0000);
		rd(8'h10, 16'h0000);
		test_done();
	end
endmodule // tb_top
`default_nettype wire
